// *** test/tlb_maintenance_ops_tb_top.sv ***
module tlb_maintenance_ops_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tlb_maint_pkg::*;

  logic mclk;
  logic nrst;
  logic cyc;
  logic stb;
  logic we;
  logic [ADDR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [31:0] c;
  logic [31:0] p;
  logic [31:0] v;
  logic [31:0] d;
  int failures;
  int checks;

  tlb_maintenance_ops uut (
    .mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack)
  );

  tlb_miss_handler_model pm (
    .mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .wdat(wdat), .rdat(rdat), .ack(ack)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    give_verdict();
  end

  initial begin
    failures = 0;
    checks = 0;
    nrst = 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    pm.rd(MACHINE_STATE_OFF, d);
    chk(d, MACHINE_STATE_RESET);
    pm.rd(STATUS_OFF, d);
    chk(d, WORD_RESET);
    pm.wr(8'h30, 32'hFFFF_FFFF);
    pm.rd(8'h30, d);
    chk(d, 32'h0000_0000);
    pm.wr({SEGMENT_REGION, 6'h3C}, 32'h0F0F_1234);
    pm.wr({SEGMENT_REGION, 6'h00}, 32'h0000_00A5);
    pm.rd({SEGMENT_REGION, 6'h3C}, d);
    chk(d, 32'h0F0F_1234);
    pm.rd({SEGMENT_REGION, 6'h00}, d);
    chk(d, 32'h0000_00A5);
    pm.load_entry(OP_LOAD_DATA, 32'hA5A5_0001, 32'h1234_5000, 5'd31, 1'b1);
    pm.load_entry(OP_LOAD_DATA, 32'h0BAD_0002, 32'h0000_F000, 5'd30, 1'b0);
    pm.load_entry(OP_LOAD_INSTR, 32'hC3C3_0003, 32'h5678_9000, 5'd31, 1'b0);
    pm.peek(1'b0, 1'b1, 5'd31, c, p, v);
    chk(c, 32'hA5A5_0001);
    chk(p, 32'h1234_5000);
    chk(v, 32'h0000_0001);
    pm.peek(1'b1, 1'b0, 5'd31, c, p, v);
    chk(c, 32'hC3C3_0003);
    chk(p, 32'h5678_9000);
    chk(v, 32'h0000_0001);
    pm.peek(1'b0, 1'b0, 5'd31, c, p, v);
    chk(v, 32'h0000_0000);
    pm.peek(1'b1, 1'b1, 5'd31, c, p, v);
    chk(v, 32'h0000_0000);
    pm.rd(COMMAND_OFF, d);
    chk(d, 32'h0000_0000);
    pm.invalidate(5'd31);
    pm.peek(1'b0, 1'b1, 5'd31, c, p, v);
    chk(v, 32'h0000_0000);
    pm.peek(1'b1, 1'b0, 5'd31, c, p, v);
    chk(v, 32'h0000_0000);
    pm.peek(1'b0, 1'b0, 5'd30, c, p, v);
    chk(v, 32'h0000_0001);
    pm.wr(COMMAND_OFF, 32'(OP_NONE));
    pm.peek(1'b0, 1'b0, 5'd30, c, p, v);
    chk(c, 32'h0BAD_0002);
    chk(v, 32'h0000_0001);
    pm.wr(MACHINE_STATE_OFF, 32'h1 << MSR_USER_BIT);
    pm.load_entry(OP_LOAD_DATA, 32'h1111_1111, 32'h2222_2000, 5'd5, 1'b0);
    pm.rd(STATUS_OFF, d);
    chk(d, 32'h1 << STAT_PRIV_BIT);
    pm.peek(1'b0, 1'b0, 5'd5, c, p, v);
    chk(v, 32'h0000_0000);
    pm.wr(STATUS_OFF, 32'h1 << STAT_PRIV_BIT);
    pm.rd(STATUS_OFF, d);
    chk(d, 32'h0000_0000);
    pm.wr(MACHINE_STATE_OFF, 32'h1 << MSR_DTRANS_BIT);
    pm.load_entry(OP_LOAD_DATA, 32'h3333_0004, 32'h4444_7000, 5'd3, 1'b1);
    pm.rd(STATUS_OFF, d);
    chk(d, 32'h1 << STAT_UNSYNC_BIT);
    pm.peek(1'b0, 1'b1, 5'd3, c, p, v);
    chk(c, 32'h3333_0004);
    chk(p, 32'h4444_7000);
    chk(v, 32'h0000_0001);
    pm.wr(STATUS_OFF, 32'h1 << STAT_UNSYNC_BIT);
    pm.rd(STATUS_OFF, d);
    chk(d, 32'h0000_0000);
    pm.wr(MACHINE_STATE_OFF, MACHINE_STATE_RESET);
    pm.clear_all();
    pm.peek(1'b0, 1'b0, 5'd30, c, p, v);
    chk(v, 32'h0000_0000);
    give_verdict();
  end
endmodule

// *** test/tlb_miss_handler_model.sv ***
module tlb_miss_handler_model (
  input wire logic mclk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [tlb_maint_pkg::ADDR_W-1:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat,
  input wire logic [31:0] rdat,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import tlb_maint_pkg::*;

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h0000_0000;
  end

  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) begin
      @(posedge mclk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    wdat <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  // Loads normally run with translation off, no fences
  // Entries written never translate the handler's own fetch
  task automatic load_entry(input tlb_op_type op, input logic [31:0] c,
                            input logic [31:0] p, input logic [4:0] idx,
                            input logic way);
    wr(op == OP_LOAD_DATA ? DATA_CMP_OFF : INSTR_CMP_OFF, c);
    wr(PHYS_ADDR_OFF, p);
    wr(SAVE_RESTORE_OFF, 32'(way) << WAY_BIT);
    wr(EA_OPERAND_OFF, 32'(idx) << EA_INDEX_LSB);
    wr(COMMAND_OFF, 32'(op));
  endtask

  task automatic invalidate(input logic [4:0] idx);
    wr(EA_OPERAND_OFF, 32'(idx) << EA_INDEX_LSB);
    wr(COMMAND_OFF, 32'(OP_INVALIDATE));
  endtask

  // Whole clear is 32 invalidates stepping the index
  task automatic clear_all();
    for (int i = 0; i < SETS; i++) begin
      invalidate(i[4:0]);
    end
  endtask

  task automatic peek(input logic t, input logic w, input logic [4:0] s,
                      output logic [31:0] c, output logic [31:0] p,
                      output logic [31:0] v);
    wr(LOOKUP_OFF, 32'(s) | (32'(w) << LK_WAY_BIT) | (32'(t) << LK_TLB_BIT));
    rd(ENTRY_CMP_OFF, c);
    rd(ENTRY_PHYS_OFF, p);
    rd(ENTRY_VALID_OFF, v);
  endtask
endmodule

// *** verilog/tlb_maint_pkg.sv ***
package tlb_maint_pkg;

  // Bus window and register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] DATA_CMP_OFF = 8'h00;
  localparam logic [7:0] INSTR_CMP_OFF = 8'h04;
  localparam logic [7:0] PHYS_ADDR_OFF = 8'h08;
  localparam logic [7:0] SAVE_RESTORE_OFF = 8'h0C;
  localparam logic [7:0] MACHINE_STATE_OFF = 8'h10;
  localparam logic [7:0] EA_OPERAND_OFF = 8'h14;
  localparam logic [7:0] COMMAND_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1C;
  localparam logic [7:0] LOOKUP_OFF = 8'h20;
  localparam logic [7:0] ENTRY_CMP_OFF = 8'h24;
  localparam logic [7:0] ENTRY_PHYS_OFF = 8'h28;
  localparam logic [7:0] ENTRY_VALID_OFF = 8'h2C;
  localparam logic [1:0] SEGMENT_REGION = 2'h1;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] MACHINE_STATE_RESET = 32'h0000_0000;

  // Field positions
  localparam int EA_INDEX_LSB = 12;
  localparam int INDEX_W = 5;
  localparam int SETS = 32;
  localparam int WAYS = 2;
  localparam int WAY_BIT = 17;
  localparam int MSR_ITRANS_BIT = 5;
  localparam int MSR_DTRANS_BIT = 4;
  localparam int MSR_USER_BIT = 14;
  localparam int STAT_PRIV_BIT = 0;
  localparam int STAT_UNSYNC_BIT = 1;
  localparam int LK_WAY_BIT = 5;
  localparam int LK_TLB_BIT = 8;
  localparam int LK_W = 9;
  localparam int SEG_COUNT = 16;
  localparam int ENTRY_W = 64;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_INVALIDATE,
    OP_LOAD_DATA,
    OP_LOAD_INSTR
  } tlb_op_type;

endpackage

// *** verilog/tlb_maintenance_ops.sv ***
// The Wishbone register port and the placing of the registers are this design's own decisions.
module tlb_maintenance_ops #(
  parameter int WAY_SEL_BIT = tlb_maint_pkg::WAY_BIT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tlb_maint_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import tlb_maint_pkg::*;

  if (WAY_SEL_BIT < 0 || WAY_SEL_BIT > 31) begin : g_check
    $error("tlb_maintenance_ops: way bit must lie within the word");
  end

  localparam int EA_W = INDEX_W + 1;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Bus handshake
  logic ack_wait;
  logic ack;
  logic [31:0] rd_word;
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_go = req & wb_we_i & ack;
  wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};

  // Address decode
  wire hit_data_pte_compare_reg = word_adr == DATA_CMP_OFF;
  wire hit_instr_pte_compare_reg = word_adr == INSTR_CMP_OFF;
  wire hit_phys = word_adr == PHYS_ADDR_OFF;
  wire hit_srr = word_adr == SAVE_RESTORE_OFF;
  wire hit_msr = word_adr == MACHINE_STATE_OFF;
  wire hit_ea = word_adr == EA_OPERAND_OFF;
  wire hit_cmd = word_adr == COMMAND_OFF;
  wire hit_status = word_adr == STATUS_OFF;
  wire hit_lookup = word_adr == LOOKUP_OFF;
  wire hit_ecmp = word_adr == ENTRY_CMP_OFF;
  wire hit_ephys = word_adr == ENTRY_PHYS_OFF;
  wire hit_evalid = word_adr == ENTRY_VALID_OFF;
  wire hit_seg = word_adr[7:6] == SEGMENT_REGION;

  // Software visible registers
  logic [31:0] data_pte_compare_reg;
  logic [31:0] instr_pte_compare_reg;
  logic [31:0] required_phys_addr_reg;
  logic [31:0] save_restore_reg_one;
  logic [31:0] machine_state_reg;
  logic [31:0] ea_operand;
  logic [LK_W-1:0] lookup_sel;
  logic priv_fault;
  logic unsync_load;

  // Valid bits per TLB, way and set
  logic [WAYS-1:0][SETS-1:0] dtlb_valid;
  logic [WAYS-1:0][SETS-1:0] itlb_valid;

  // Operation decode
  wire cmd_go = wr_go & hit_cmd & wb_sel_i[0];
  wire tlb_op_type op = tlb_op_type'(wb_dat_i[1:0]);
  wire [INDEX_W-1:0] set_idx = ea_operand[EA_INDEX_LSB +: INDEX_W];
  wire way = save_restore_reg_one[WAY_SEL_BIT];
  wire user_mode = machine_state_reg[MSR_USER_BIT];
  wire xlate_on = machine_state_reg[MSR_ITRANS_BIT]
      | machine_state_reg[MSR_DTRANS_BIT];
  wire is_load = (op == OP_LOAD_DATA) | (op == OP_LOAD_INSTR);
  wire inval = cmd_go & (op == OP_INVALIDATE);
  wire dload = cmd_go & (op == OP_LOAD_DATA) & !user_mode;
  wire iload = cmd_go & (op == OP_LOAD_INSTR) & !user_mode;
  wire priv_hit = cmd_go & is_load & user_mode;
  wire unsync_hit = cmd_go & is_load & !user_mode & xlate_on;
  wire stat_clr = wr_go & hit_status & wb_sel_i[0];
  wire [31:0] lookup_merged = merge_lanes({23'h0, lookup_sel}, wb_dat_i,
      wb_sel_i);

  // Entry storage
  wire [EA_W-1:0] load_addr = {way, set_idx};
  wire [EA_W-1:0] look_addr = {lookup_sel[LK_WAY_BIT],
      lookup_sel[INDEX_W-1:0]};
  wire [ENTRY_W-1:0] dmem_wr_data = {data_pte_compare_reg,
      required_phys_addr_reg};
  wire [ENTRY_W-1:0] imem_wr_data = {instr_pte_compare_reg,
      required_phys_addr_reg};
  logic [ENTRY_W-1:0] dmem_rd;
  logic [ENTRY_W-1:0] imem_rd;
  logic [31:0] seg_rd;
  wire seg_we = wr_go & hit_seg & (wb_sel_i == 4'hF);

  tlb_word_mem #(.WIDTH(ENTRY_W), .DEPTH(WAYS * SETS)) dtlb_mem (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(dload),
    .wr_addr(load_addr),
    .wr_data(dmem_wr_data),
    .rd_addr(look_addr),
    .rd_data(dmem_rd)
  );

  tlb_word_mem #(.WIDTH(ENTRY_W), .DEPTH(WAYS * SETS)) itlb_mem (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(iload),
    .wr_addr(load_addr),
    .wr_data(imem_wr_data),
    .rd_addr(look_addr),
    .rd_data(imem_rd)
  );

  // Segment descriptors
  tlb_word_mem #(.WIDTH(32), .DEPTH(SEG_COUNT)) seg_mem (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(seg_we),
    .wr_addr(wb_adr_i[5:2]),
    .wr_data(wb_dat_i),
    .rd_addr(wb_adr_i[5:2]),
    .rd_data(seg_rd)
  );

  // Read selection
  wire look_instr = lookup_sel[LK_TLB_BIT];
  wire [ENTRY_W-1:0] entry_rd = look_instr ? imem_rd : dmem_rd;
  wire entry_valid = look_instr
      ? itlb_valid[look_addr[INDEX_W]][look_addr[INDEX_W-1:0]]
      : dtlb_valid[look_addr[INDEX_W]][look_addr[INDEX_W-1:0]];
  wire [31:0] status_word = {30'h0, unsync_load, priv_fault};
  assign rd_word =
      hit_data_pte_compare_reg ? data_pte_compare_reg :
      hit_instr_pte_compare_reg ? instr_pte_compare_reg :
      hit_phys ? required_phys_addr_reg :
      hit_srr ? save_restore_reg_one :
      hit_msr ? machine_state_reg :
      hit_ea ? ea_operand :
      hit_status ? status_word :
      hit_lookup ? {23'h0, lookup_sel} :
      hit_ecmp ? entry_rd[ENTRY_W-1:32] :
      hit_ephys ? entry_rd[31:0] :
      hit_evalid ? {31'h0, entry_valid} :
      hit_seg ? seg_rd : 32'h0;

  // Two-edge answer: the segment store needs one edge to read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_wait <= 1'b0;
      ack <= 1'b0;
      wb_dat_o <= WORD_RESET;
    end else begin
      ack_wait <= req & !ack & !ack_wait;
      ack <= ack_wait;
      if (ack_wait) begin
        wb_dat_o <= rd_word;
      end
    end
  end
  assign wb_ack_o = ack;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_pte_compare_reg <= WORD_RESET;
      instr_pte_compare_reg <= WORD_RESET;
      required_phys_addr_reg <= WORD_RESET;
      save_restore_reg_one <= WORD_RESET;
      machine_state_reg <= MACHINE_STATE_RESET;
      ea_operand <= WORD_RESET;
      lookup_sel <= '0;
    end else if (wr_go) begin
      if (hit_data_pte_compare_reg) begin
        data_pte_compare_reg <= merge_lanes(data_pte_compare_reg,
            wb_dat_i, wb_sel_i);
      end
      if (hit_instr_pte_compare_reg) begin
        instr_pte_compare_reg <= merge_lanes(instr_pte_compare_reg,
            wb_dat_i, wb_sel_i);
      end
      if (hit_phys) begin
        required_phys_addr_reg <= merge_lanes(required_phys_addr_reg,
            wb_dat_i, wb_sel_i);
      end
      if (hit_srr) begin
        save_restore_reg_one <= merge_lanes(save_restore_reg_one,
            wb_dat_i, wb_sel_i);
      end
      if (hit_msr) begin
        machine_state_reg <= merge_lanes(machine_state_reg,
            wb_dat_i, wb_sel_i);
      end
      if (hit_ea) begin
        ea_operand <= merge_lanes(ea_operand, wb_dat_i, wb_sel_i);
      end
      if (hit_lookup) begin
        lookup_sel <= lookup_merged[LK_W-1:0];
      end
    end
  end

  // Sticky status, a new event wins over a clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      priv_fault <= 1'b0;
      unsync_load <= 1'b0;
    end else begin
      priv_fault <= priv_hit
          | (priv_fault & !(stat_clr & wb_dat_i[STAT_PRIV_BIT]));
      unsync_load <= unsync_hit
          | (unsync_load & !(stat_clr & wb_dat_i[STAT_UNSYNC_BIT]));
    end
  end

  // Invalidate hits the indexed set of every way of both TLBs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dtlb_valid <= '0;
      itlb_valid <= '0;
    end else if (inval) begin
      for (int w = 0; w < WAYS; w++) begin
        dtlb_valid[w][set_idx] <= 1'b0;
        itlb_valid[w][set_idx] <= 1'b0;
      end
    end else if (dload) begin
      dtlb_valid[way][set_idx] <= 1'b1;
    end else if (iload) begin
      itlb_valid[way][set_idx] <= 1'b1;
    end
  end

  // Last loaded entry of each TLB, for the read-back checks
  logic [EA_W-1:0] last_daddr;
  logic [EA_W-1:0] last_iaddr;
  logic [ENTRY_W-1:0] last_dword;
  logic [ENTRY_W-1:0] last_iword;
  logic dload_done;
  logic iload_done;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_daddr <= '0;
      last_iaddr <= '0;
      last_dword <= '0;
      last_iword <= '0;
      dload_done <= 1'b0;
      iload_done <= 1'b0;
    end else begin
      if (dload) begin
        last_daddr <= {way, set_idx};
        last_dword <= {data_pte_compare_reg, required_phys_addr_reg};
        dload_done <= 1'b1;
      end
      if (iload) begin
        last_iaddr <= {way, set_idx};
        last_iword <= {instr_pte_compare_reg, required_phys_addr_reg};
        iload_done <= 1'b1;
      end
    end
  end

  // Checks
  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  wire [2*WAYS*SETS-1:0] all_valid = {dtlb_valid, itlb_valid};

  inval_clears_four_a: assert property (
    inval |=> !dtlb_valid[0][$past(set_idx)] && !dtlb_valid[1][$past(set_idx)]
        && !itlb_valid[0][$past(set_idx)] && !itlb_valid[1][$past(set_idx)])
    else $error("invalidate left a valid entry in the indexed set");

  inval_index_only_a: assert property (
    inval |=> ((dtlb_valid[0] ^ $past(dtlb_valid[0]))
        & ~(32'h1 << $past(set_idx))) == 32'h0)
    else $error("invalidate touched a set outside the EA index");

  no_clear_all_a: assert property (
    $countones($past(all_valid) & ~all_valid) <= 4)
    else $error("more than four entries dropped in one cycle");

  ea_direct_a: assert property (
    dload |=> dtlb_valid[$past(way)][$past(ea_operand[16:12])])
    else $error("load index differs from operand EA bits");

  data_word_a: assert property (
    dload_done && !look_instr && look_addr == last_daddr && !dload
        |=> dmem_rd == last_dword)
    else $error("data entry does not hold compare and physical words");

  data_way_a: assert property (
    dload && !dtlb_valid[!way][set_idx]
        |=> !dtlb_valid[!$past(way)][$past(set_idx)])
    else $error("data load wrote the unselected way");

  instr_word_a: assert property (
    iload_done && look_instr && look_addr == last_iaddr && !iload
        |=> imem_rd == last_iword)
    else $error("instr entry does not hold compare and physical words");

  instr_sel_a: assert property (
    iload |=> itlb_valid[$past(way)][$past(set_idx)] && $stable(dtlb_valid))
    else $error("instr load missed its selected entry");

  user_refused_a: assert property (
    priv_hit |=> $stable(dtlb_valid) && $stable(itlb_valid) && priv_fault)
    else $error("user mode load was not refused");

  load_one_entry_a: assert property (
    (dload || iload) |=> $countones(all_valid ^ $past(all_valid)) <= 1
        && $stable(machine_state_reg) && $stable(save_restore_reg_one))
    else $error("load altered more than the selected entry");

  ack_pulse_a: assert property (ack |=> !ack)
    else $error("bus answer held longer than one cycle");

  ack_delay_a: assert property ($rose(req) |-> ##2 ack)
    else $error("bus answer not given two edges after the request");

  inval_seen_c: cover property (inval);
  dload_seen_c: cover property (dload ##[1:40] iload);
  refused_seen_c: cover property (priv_hit);
  unsync_seen_c: cover property (unsync_hit);

endmodule

// *** verilog/tlb_word_mem.sv ***
module tlb_word_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  if (DEPTH < 2 || WIDTH < 1 || (1 << AW) != DEPTH) begin : g_check
    $error("tlb_word_mem: depth must be a power of two, width positive");
  end

  // Array itself has no reset
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= store[rd_addr];
    end
  end

endmodule
